// ### debug_pkg.sv
// Shared constants and types for the debug watch and event counter unit.
// Functional notes
// - Two watch comparators, each load/store/fetch enabled.
// - Compare physical addresses only.
// - Shared mask bits 31:2 give power-of-two ranges.
// - Load/store match raises data watch, code 23.
// - Fetch match raises instruction watch, code 16.
// - Cause bits 25..24 name matching comparator.
// - Enables at 63/62/61, address 35:2, rest zero.
// - 32-bit writable counter; bit 31 requests interrupt.
// - Five-bit event select, codes 00 to 1E.
// - Only the selected event is ever counted.
// - Bit 8 kernel, bit 9 user, bit 10 enable.
// - Interrupt delivered only with global enable set and mask clear.
// - Counter interrupt appears as pending source 13.
package debug_pkg;

	localparam int ADDR_W    = 36;
	localparam int DATA_W    = 64;
	localparam int CNT_W     = 32;
	localparam int NUM_WATCH = 2;
	localparam int EVT_W     = 5;
	localparam int NUM_EVT   = 31;
	localparam int SEL_W     = 3;
	localparam int CODE_W    = 5;

	// ****************************************************************
	// Register numbers on the system control coprocessor port.
	// ****************************************************************
	localparam logic [SEL_W-1:0] REG_WATCH_A  = 3'h0;
	localparam logic [SEL_W-1:0] REG_WATCH_B  = 3'h1;
	localparam logic [SEL_W-1:0] REG_MASK     = 3'h2;
	localparam logic [SEL_W-1:0] REG_CNT_VAL  = 3'h3;
	localparam logic [SEL_W-1:0] REG_CNT_CTL  = 3'h4;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int WATCH_STORE_BIT = 63;
	localparam int WATCH_LOAD_BIT  = 62;
	localparam int WATCH_INSTR_BIT = 61;
	localparam int WATCH_ADDR_HI   = 35;
	localparam int WATCH_ADDR_LO   = 2;
	localparam int MASK_HI         = 31;
	localparam int MASK_LO         = 2;
	localparam int CTL_EVT_HI      = 4;
	localparam int CTL_EVT_LO      = 0;
	localparam int CTL_KERNEL_BIT  = 8;
	localparam int CTL_USER_BIT    = 9;
	localparam int CTL_ENABLE_BIT  = 10;
	localparam int CNT_IRQ_BIT     = 31;

	// Bits of a watch register that hold state; all others read zero.
	localparam logic [DATA_W-1:0] WATCH_KEEP = 64'he000_000f_ffff_fffc;

	// ****************************************************************
	// Codes and reset values.
	// ****************************************************************
	localparam logic [CODE_W-1:0] EXC_DATA_WATCH  = 5'h17;
	localparam logic [CODE_W-1:0] EXC_INSTR_WATCH = 5'h10;
	localparam logic [EVT_W-1:0]  EVT_CLOCK       = 5'h00;
	localparam logic [EVT_W-1:0]  EVT_LAST        = 5'h1e;
	localparam logic [DATA_W-1:0] WATCH_RESET     = 64'h0;
	localparam logic [CNT_W-1:0]  MASK_RESET      = 32'h0;
	localparam logic [CNT_W-1:0]  CNT_RESET       = 32'h0;

	typedef enum logic [1:0] {ACC_LOAD, ACC_STORE, ACC_FETCH} access_kind_t;

	typedef struct packed {
		logic              valid;
		access_kind_t      kind;
		logic [ADDR_W-1:0] paddr;
	} access_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [SEL_W-1:0]  sel;
		logic [DATA_W-1:0] wdata;
	} cp0_req_t;

	typedef struct packed {
		logic              valid;
		logic [CODE_W-1:0] code;
		logic              second_match_flag;
		logic              first_match_flag;
	} watch_exc_t;

	typedef struct packed {
		logic             enable;
		logic             user;
		logic             kernel;
		logic [EVT_W-1:0] event_sel;
	} cnt_ctl_t;

endpackage : debug_pkg

// ### debug_watch_perf.sv
// Debug unit: two address watch comparators and one event counter.
`timescale 1ns/1ps
module debug_watch_perf
#(
	parameter int NUM_EVENTS = debug_pkg::NUM_EVT
)
(
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire debug_pkg::cp0_req_t           cp0_req,
	output logic [debug_pkg::DATA_W-1:0]       rdata_r,
	input  wire debug_pkg::access_t            access,
	output debug_pkg::watch_exc_t              watch_exc_r,
	input  wire logic                          kernel_mode,
	input  wire logic [NUM_EVENTS-1:0]         event_vec,
	input  wire logic                          global_irq_enable,
	input  wire logic                          counter_irq_mask,
	output logic                               counter_irq_pending_r,
	output logic                               counter_irq_r
);
	import debug_pkg::*;

	// ****************************************************************
	// Register state.
	// ****************************************************************
	logic [DATA_W-1:0]    watch_r [NUM_WATCH];
	logic [CNT_W-1:0]     mask_r;
	logic [CNT_W-1:0]     cnt_r;
	logic [CNT_W-1:0]     cnt_nxt;
	cnt_ctl_t             ctl_r;
	logic [NUM_WATCH-1:0] hits;
	logic                 wr_watch_a;
	logic                 wr_watch_b;
	logic                 wr_mask;
	logic                 wr_cnt;
	logic                 wr_ctl;
	logic                 evt_occ;
	logic                 priv_ok;
	logic                 count_now;

	assign wr_watch_a = cp0_req.wr && (cp0_req.sel == REG_WATCH_A);
	assign wr_watch_b = cp0_req.wr && (cp0_req.sel == REG_WATCH_B);
	assign wr_mask    = cp0_req.wr && (cp0_req.sel == REG_MASK);
	assign wr_cnt     = cp0_req.wr && (cp0_req.sel == REG_CNT_VAL);
	assign wr_ctl     = cp0_req.wr && (cp0_req.sel == REG_CNT_CTL);

	// ****************************************************************
	// Watch registers.
	// ****************************************************************
	// Only enables and address bits are stored, so the rest read zero.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			watch_r[0] <= WATCH_RESET;
			watch_r[1] <= WATCH_RESET;
		end
		else
		begin
			if (wr_watch_a)
			begin
				watch_r[0] <= cp0_req.wdata & WATCH_KEEP;
			end
			if (wr_watch_b)
			begin
				watch_r[1] <= cp0_req.wdata & WATCH_KEEP;
			end
		end
	end

	// ****************************************************************
	// Range mask register.
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			mask_r <= MASK_RESET;
		end
		else if (wr_mask)
		begin
			mask_r <= cp0_req.wdata[CNT_W-1:0];
		end
	end

	// ****************************************************************
	// Comparators.
	// ****************************************************************
	generate
		for (genvar i = 0; i < NUM_WATCH; i++)
		begin : g_watch
			watch_compare u_cmp
			(
				.watch_reg  (watch_r[i]),
				.range_mask (mask_r),
				.use_mask   (mask_r[i]),
				.access     (access),
				.hit        (hits[i])
			);
		end
	endgenerate

	// ****************************************************************
	// Watch exception report.
	// ****************************************************************
	// The report follows the access by one cycle and lasts one cycle.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			watch_exc_r <= '0;
		end
		else
		begin
			watch_exc_r.valid             <= |hits;
			watch_exc_r.first_match_flag  <= hits[0];
			watch_exc_r.second_match_flag <= hits[1];
			if (access.kind == ACC_FETCH)
			begin
				watch_exc_r.code <= EXC_INSTR_WATCH;
			end
			else
			begin
				watch_exc_r.code <= EXC_DATA_WATCH;
			end
		end
	end

	// ****************************************************************
	// Counter control register.
	// ****************************************************************
	// Reserved bits are not stored and read back as zero.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ctl_r <= '0;
		end
		else if (wr_ctl)
		begin
			ctl_r.event_sel <= cp0_req.wdata[CTL_EVT_HI:CTL_EVT_LO];
			ctl_r.kernel    <= cp0_req.wdata[CTL_KERNEL_BIT];
			ctl_r.user      <= cp0_req.wdata[CTL_USER_BIT];
			ctl_r.enable    <= cp0_req.wdata[CTL_ENABLE_BIT];
		end
	end

	// ****************************************************************
	// Event selection and counting.
	// ****************************************************************
	// Code 00 counts every cycle; codes above the last one count nothing.
	always_comb
	begin
		if (ctl_r.event_sel == EVT_CLOCK)
		begin
			evt_occ = 1'b1;
		end
		else if ((ctl_r.event_sel <= EVT_LAST) && (32'(ctl_r.event_sel) < NUM_EVENTS))
		begin
			evt_occ = event_vec[ctl_r.event_sel];
		end
		else
		begin
			evt_occ = 1'b0;
		end
	end

	assign priv_ok   = kernel_mode ? ctl_r.kernel : ctl_r.user;
	assign count_now = ctl_r.enable && priv_ok && evt_occ;

	// A software write wins over a count in the same cycle.
	always_comb
	begin
		if (wr_cnt)
		begin
			cnt_nxt = cp0_req.wdata[CNT_W-1:0];
		end
		else if (count_now)
		begin
			cnt_nxt = cnt_r + 32'h1;
		end
		else
		begin
			cnt_nxt = cnt_r;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			cnt_r <= CNT_RESET;
		end
		else
		begin
			cnt_r <= cnt_nxt;
		end
	end

	// ****************************************************************
	// Counter interrupt.
	// ****************************************************************
	// Pending follows bit 31 of the counter; rewriting the counter loads it from bit 31 of the written value.
	// The interrupt passes only while the mask bit of source 13 is clear.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			counter_irq_pending_r <= 1'b0;
			counter_irq_r         <= 1'b0;
		end
		else
		begin
			counter_irq_pending_r <= cnt_nxt[CNT_IRQ_BIT];
			counter_irq_r         <= cnt_nxt[CNT_IRQ_BIT] && global_irq_enable
				&& !counter_irq_mask;
		end
	end

	// ****************************************************************
	// Register read.
	// ****************************************************************
	// Read data appear one cycle after the request and hold until the next.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			rdata_r <= '0;
		end
		else if (cp0_req.rd)
		begin
			unique case (cp0_req.sel)
				REG_WATCH_A: rdata_r <= watch_r[0];
				REG_WATCH_B: rdata_r <= watch_r[1];
				REG_MASK:    rdata_r <= {32'h0, mask_r};
				REG_CNT_VAL: rdata_r <= {32'h0, cnt_r};
				REG_CNT_CTL: rdata_r <= {53'h0, ctl_r.enable, ctl_r.user, ctl_r.kernel,
					3'h0, ctl_r.event_sel};
				default:     rdata_r <= '0;
			endcase
		end
	end

endmodule : debug_watch_perf

// ### debug_watch_perf_chk.sv
// Concurrent checks on the ports of the debug watch and event counter unit.
`timescale 1ns/1ps
module debug_watch_perf_chk
#(
	parameter int NUM_EVENTS = 31
)
(
	input wire logic                          clk,
	input wire logic                          resetn,
	input wire debug_pkg::cp0_req_t           cp0_req,
	input wire logic [debug_pkg::DATA_W-1:0]  rdata_r,
	input wire debug_pkg::access_t            access,
	input wire debug_pkg::watch_exc_t         watch_exc_r,
	input wire logic                          kernel_mode,
	input wire logic [NUM_EVENTS-1:0]         event_vec,
	input wire logic                          global_irq_enable,
	input wire logic                          counter_irq_mask,
	input wire logic                          counter_irq_pending_r,
	input wire logic                          counter_irq_r
);
	import debug_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	chk_exc_cause: assert property (
		watch_exc_r.valid |-> $past(access.valid)) else $error("Watch hit without access");
	chk_fetch_code: assert property (
		watch_exc_r.valid && $past(access.kind) == ACC_FETCH
		|-> watch_exc_r.code == EXC_INSTR_WATCH) else $error("Fetch watch code wrong");
	chk_data_code: assert property (
		watch_exc_r.valid && $past(access.kind) != ACC_FETCH
		|-> watch_exc_r.code == EXC_DATA_WATCH) else $error("Data watch code wrong");
	chk_match_flag: assert property (
		watch_exc_r.valid |-> watch_exc_r.first_match_flag || watch_exc_r.second_match_flag)
		else $error("Watch hit names no comparator");
	chk_watch_zero: assert property (
		cp0_req.rd && cp0_req.sel <= REG_WATCH_B |=> (rdata_r & ~WATCH_KEEP) == '0)
		else $error("Watch register spare bits not zero");
	chk_ctl_zero: assert property (
		cp0_req.rd && cp0_req.sel == REG_CNT_CTL |=> rdata_r[63:11] == '0 && rdata_r[7:5] == '0)
		else $error("Control reserved bits not zero");
	chk_unmapped_zero: assert property (
		cp0_req.rd && cp0_req.sel > REG_CNT_CTL |=> rdata_r == '0)
		else $error("Unmapped read not zero");
	chk_cnt_write: assert property (
		cp0_req.wr && cp0_req.sel == REG_CNT_VAL |=> counter_irq_pending_r == $past(cp0_req.wdata[31]))
		else $error("Pending does not follow counter write");
	chk_irq_gate: assert property (
		counter_irq_r == (counter_irq_pending_r && $past(global_irq_enable)
		&& !$past(counter_irq_mask))) else $error("Counter interrupt gating wrong");
	cover property (watch_exc_r.valid && watch_exc_r.code == EXC_INSTR_WATCH);
	cover property (watch_exc_r.valid && watch_exc_r.code == EXC_DATA_WATCH);
	cover property ($rose(counter_irq_r));
endmodule : debug_watch_perf_chk

bind debug_watch_perf debug_watch_perf_chk #(.NUM_EVENTS(NUM_EVENTS)) chk_inst (.clk(clk),
	.resetn(resetn), .cp0_req(cp0_req), .rdata_r(rdata_r), .access(access),
	.watch_exc_r(watch_exc_r), .kernel_mode(kernel_mode), .event_vec(event_vec),
	.global_irq_enable(global_irq_enable), .counter_irq_mask(counter_irq_mask),
	.counter_irq_pending_r(counter_irq_pending_r), .counter_irq_r(counter_irq_r));

// ### debug_watch_perf_tb_top.sv
// Self-checking testbench for the debug watch and event counter unit.
`timescale 1ns/1ps
module debug_watch_perf_tb_top;
	import debug_pkg::*;
	logic             clk = 0, resetn = 0, global_irq_enable = 0, counter_irq_mask = 0;
	cp0_req_t         cp0_req = '0;
	logic [35:0]      base = '0;
	access_t          access;
	logic             kernel_mode, pend, irq, exp_pend = 0, exp_irq = 0;
	logic [30:0]      event_vec;
	logic [63:0]      rdata_r, exp_rd = '0;
	logic [63:0]      m [0:4];
	watch_exc_t       watch_exc_r, exp_exc = '0;
	int               fail_count = 0, checked = 0;
	always #4 clk = ~clk;
	debug_watch_perf debug_watch_perf_inst (.clk(clk), .resetn(resetn), .cp0_req(cp0_req),
		.rdata_r(rdata_r), .access(access), .watch_exc_r(watch_exc_r),
		.kernel_mode(kernel_mode), .event_vec(event_vec),
		.global_irq_enable(global_irq_enable), .counter_irq_mask(counter_irq_mask),
		.counter_irq_pending_r(pend), .counter_irq_r(irq));
	pipe_model pipe_model_inst (.clk(clk), .base(base), .access(access),
		.kernel_mode(kernel_mode), .event_vec(event_vec));
	// ****************************************************************
	// Reference model, stepped on the same edges as the design.
	// ****************************************************************
	always @(posedge clk)
	begin : model
		logic [63:0] keep;
		logic [35:0] ign;
		logic [31:0] n;
		logic [1:0]  hit;
		int          s;
		s = int'(cp0_req.sel);
		n = m[3][31:0];
		if (!resetn)
		begin
			for (int i = 0; i < 5; i++) m[i] <= '0;
			exp_rd <= '0;
			exp_exc <= '0;
			exp_pend <= 1'b0;
			exp_irq <= 1'b0;
		end
		else
		begin
			if (m[4][10] && (kernel_mode ? m[4][8] : m[4][9]) && (m[4][4:0] == 5'h0
				|| (m[4][4:0] != 5'h1f && event_vec[m[4][4:0]]))) n = n + 1;
			for (int i = 0; i < 2; i++)
			begin
				ign = m[2][i] ? {4'h0, m[2][31:2], 2'h3} : 36'h3;
				hit[i] = access.valid && ((access.paddr ^ m[i][35:0]) & ~ign) == '0
					&& m[i][access.kind == ACC_STORE ? 63 : access.kind == ACC_LOAD ? 62 : 61];
			end
			exp_exc <= '{valid: |hit, second_match_flag: hit[1], first_match_flag: hit[0],
				code: access.kind == ACC_FETCH ? EXC_INSTR_WATCH : EXC_DATA_WATCH};
			if (cp0_req.rd) exp_rd <= s < 5 ? m[s] : 64'h0;
			keep = s < 2 ? WATCH_KEEP : s == 4 ? 64'h71f : 64'hffff_ffff;
			if (cp0_req.wr && s < 5) m[s] <= cp0_req.wdata & keep;
			if (cp0_req.wr && s == 3) n = cp0_req.wdata[31:0];
			m[3] <= {32'h0, n};
			exp_pend <= n[31];
			exp_irq <= n[31] && global_irq_enable && !counter_irq_mask;
		end
	end
	always @(negedge clk)
	begin
		check(rdata_r, exp_rd);
		check({pend, irq}, {exp_pend, exp_irq});
		check(watch_exc_r.valid, exp_exc.valid);
		if (exp_exc.valid) check(watch_exc_r, exp_exc);
	end
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [2:0] sel, input logic [63:0] d);
		@(posedge clk);
		cp0_req <= '{wr: wr, rd: !wr, sel: sel, wdata: d};
		@(posedge clk);
		cp0_req <= '0;
	endtask : bus
	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	initial
	begin
		void'($urandom(32'h43b2));
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		for (int s = 0; s < 8; s++) bus(1'b0, 3'(s), '0);
		for (int s = 0; s < 8; s++)
		begin
			bus(1'b1, 3'(s), s == 4 ? 64'h71f : '1);
			bus(1'b0, 3'(s), '0);
		end
		for (int e = 0; e < 32; e++)
		begin
			base <= {4'($urandom), 32'($urandom)};
			@(posedge clk);
			bus(1'b1, REG_WATCH_A, {3'($urandom), 25'($urandom), base});
			bus(1'b1, REG_WATCH_B, {3'($urandom), 25'($urandom), base ^ 36'h10});
			bus(1'b1, REG_MASK, 64'($urandom));
			bus(1'b1, REG_CNT_VAL, {32'($urandom), 32'h7fff_fff0});
			bus(1'b1, REG_CNT_CTL, {53'h0, e[0] ? 3'h7 : 3'($urandom), 3'h0, 5'(e)});
			repeat (30)
			begin
				@(posedge clk);
				global_irq_enable <= 1'($urandom);
				counter_irq_mask <= 1'($urandom);
			end
			for (int s = 0; s < 5; s++) bus(1'b0, 3'(s), '0);
			bus(1'b1, REG_CNT_VAL, '0);
		end
		finish_test();
	end
	initial
	begin
		#80000;
		fail_count++;
		finish_test();
	end
endmodule : debug_watch_perf_tb_top

// ### pipe_model.sv
// Pipeline model that issues physical accesses and counting events.
`timescale 1ns/1ps
module pipe_model
(
	input wire logic                       clk,
	input wire logic [35:0]                base,
	output debug_pkg::access_t             access,
	output logic                           kernel_mode,
	output logic [debug_pkg::NUM_EVT-1:0]  event_vec
);
	import debug_pkg::*;
	// Addresses stay near the watched one so hits, near misses and range hits all occur.
	always @(posedge clk)
	begin
		access.valid <= 1'($urandom);
		access.kind <= access_kind_t'($urandom_range(2));
		access.paddr <= base ^ 36'(36'($urandom_range(3)) << $urandom_range(35));
		kernel_mode <= 1'($urandom);
		event_vec <= 31'($urandom);
	end
endmodule : pipe_model

// ### watch_compare.sv
// One address watch comparator with optional range mask.
`timescale 1ns/1ps
module watch_compare
(
	input  wire logic [debug_pkg::DATA_W-1:0] watch_reg,
	input  wire logic [debug_pkg::CNT_W-1:0]  range_mask,
	input  wire logic                         use_mask,
	input  wire debug_pkg::access_t           access,
	output logic                              hit
);
	import debug_pkg::*;

	localparam int CMP_W = WATCH_ADDR_HI - WATCH_ADDR_LO + 1;
	localparam int MSK_W = MASK_HI - MASK_LO + 1;

	logic [CMP_W-1:0] care;
	logic [CMP_W-1:0] diff;
	logic             kind_ok;

	always_comb
	begin
		care = '1;
		if (use_mask)
		begin
			care[MSK_W-1:0] = ~range_mask[MASK_HI:MASK_LO];
		end
		diff = access.paddr[WATCH_ADDR_HI:WATCH_ADDR_LO]
			^ watch_reg[WATCH_ADDR_HI:WATCH_ADDR_LO];
		unique case (access.kind)
			ACC_LOAD:  kind_ok = watch_reg[WATCH_LOAD_BIT];
			ACC_STORE: kind_ok = watch_reg[WATCH_STORE_BIT];
			ACC_FETCH: kind_ok = watch_reg[WATCH_INSTR_BIT];
			default:   kind_ok = 1'b0;
		endcase
		hit = access.valid && kind_ok && ((diff & care) == '0);
	end

endmodule : watch_compare
